// ### rtl/psr_pkg.sv
// Purpose: Constants for the transceiver status, identifier and advertisement bank
// Assumes: 16-bit management registers, 5-bit addresses
// Notes: Shared by the register bank and its tests
package psr_pkg;
   // Register addresses on the management bus
   localparam logic [4:0] REG_STATUS = 5'h01;
   localparam logic [4:0] REG_ID_HIGH = 5'h02;
   localparam logic [4:0] REG_ID_LOW = 5'h03;
   localparam logic [4:0] REG_ADVERT = 5'h04;

   // Status register bit positions
   localparam int ST_EXT_CAP = 0;
   localparam int ST_JABBER = 1;
   localparam int ST_LINK = 2;
   localparam int ST_AN_ABLE = 3;
   localparam int ST_REM_FAULT = 4;
   localparam int ST_AN_DONE = 5;
   localparam int ST_PRE_SUPP = 6;
   localparam int ST_EXT_STAT = 8;
   // Fixed capability pattern, live bits left as zero
   localparam logic [15:0] STATUS_FIXED = 16'h7949;

   // Advertisement register layout
   localparam logic [15:0] ADV_RESET = 16'h81e1;
   localparam logic [15:0] ADV_WR_MASK = 16'hade0;
   localparam logic [4:0] ADV_SELECTOR = 5'h01;

   // Management frame codes and lengths
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] OP_BITS = 5'h02;
   localparam logic [4:0] ADDR_BITS = 5'h0a;
   localparam logic [4:0] DATA_BITS = 5'h10;

   typedef enum logic [2:0] {
      MS_IDLE = 3'h0,
      MS_OP = 3'h1,
      MS_ADDR = 3'h3,
      MS_TURN = 3'h2,
      MS_DATA = 3'h6
   } psr_mstate_t;
endpackage

// ### rtl/psr_regs.sv
// Purpose: Status, identifier and advertisement registers behind a serial management port
// Assumes: Status inputs come from logic on mclk; mdc and mdio arrive from outside
// Notes: mdc is oversampled, so it must stay well below a quarter of mclk
`timescale 1ns/100ps
module psr_regs #(
   parameter logic [4:0] PHY_ADDR = 5'h01,
   parameter logic [15:0] ID_HIGH = 16'h5a5a, // Arbitrary value
   parameter logic [5:0] MODEL_NUM = 6'h2a, // Arbitrary value
   parameter logic [3:0] REV_NUM = 4'h1, // Arbitrary value
   parameter logic [5:0] ORG_ID_LOW = 6'h15 // Arbitrary value
) (
   input wire logic mclk, // 40 MHz system clock
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic sw_reset, // Software reset pulse from control register
   input wire logic mdc, // Management clock pin
   input wire logic mdio_i, // Management data pin, input side
   output logic mdio_o, // Management data pin, output side
   output logic mdio_oe_n, // Low while driving management data
   input wire logic jabber_det, // Jabber condition, live
   input wire logic link_up, // Link state, live
   input wire logic remote_fault_det, // Remote fault condition, live
   input wire logic an_complete, // Auto-negotiation complete, live
   output logic [15:0] adv_q // Advertisement register contents
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [1:0] mdc_sync_q;
   logic [1:0] mdio_sync_q;
   logic mdc_prev_q;
   logic mdc_rise;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         // All high, so a clock parked high over reset gives no false edge
         mdc_sync_q <= 2'h3;
         mdio_sync_q <= 2'h3;
         mdc_prev_q <= 1'b1;
      end
      else
      begin
         mdc_sync_q <= {mdc_sync_q[0], mdc};
         mdio_sync_q <= {mdio_sync_q[0], mdio_i};
         mdc_prev_q <= mdc_sync_q[1];
      end
   end

   assign mdc_rise = mdc_sync_q[1] & ~mdc_prev_q;

   ////////////////////////////////////////////////////////////////////////////
   // Management frame receiver and read driver

   psr_pkg::psr_mstate_t state_q;
   logic [4:0] cnt_q;
   logic [1:0] op_q;
   logic [9:0] addr_q;
   logic [15:0] shift_q;
   logic prev_bit_q;
   logic rd_active_q;
   logic bit_in;
   logic [15:0] rd_data;
   logic [15:0] status_rd;
   logic addr_hit;
   logic reg_mapped;
   logic status_rd_ev;
   logic adv_wr_ev;

   assign bit_in = mdio_sync_q[1];
   assign addr_hit = addr_q[9:5] == PHY_ADDR;
   assign reg_mapped = addr_q[4:0] >= psr_pkg::REG_STATUS && addr_q[4:0] <= psr_pkg::REG_ADVERT;

   // No preamble needed: a zero then a one marks the start
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= psr_pkg::MS_IDLE;
         cnt_q <= 5'h0;
         op_q <= 2'h0;
         addr_q <= 10'h0;
         prev_bit_q <= 1'b1;
      end
      else if (mdc_rise)
      begin
         prev_bit_q <= bit_in;
         unique case (state_q)
            psr_pkg::MS_IDLE:
            begin
               cnt_q <= 5'h0;
               if (!prev_bit_q && bit_in)
               begin
                  state_q <= psr_pkg::MS_OP;
               end
            end
            psr_pkg::MS_OP:
            begin
               op_q <= {op_q[0], bit_in};
               if (cnt_q == psr_pkg::OP_BITS - 5'h1)
               begin
                  state_q <= psr_pkg::MS_ADDR;
                  cnt_q <= 5'h0;
               end
               else
               begin
                  cnt_q <= cnt_q + 5'h1;
               end
            end
            psr_pkg::MS_ADDR:
            begin
               addr_q <= {addr_q[8:0], bit_in};
               if (cnt_q == psr_pkg::ADDR_BITS - 5'h1)
               begin
                  state_q <= psr_pkg::MS_TURN;
                  cnt_q <= 5'h0;
               end
               else
               begin
                  cnt_q <= cnt_q + 5'h1;
               end
            end
            psr_pkg::MS_TURN:
            begin
               if (cnt_q == 5'h1)
               begin
                  state_q <= psr_pkg::MS_DATA;
                  cnt_q <= 5'h0;
               end
               else
               begin
                  cnt_q <= cnt_q + 5'h1;
               end
            end
            psr_pkg::MS_DATA:
            begin
               if (cnt_q == psr_pkg::DATA_BITS - 5'h1)
               begin
                  state_q <= psr_pkg::MS_IDLE;
                  prev_bit_q <= 1'b1;
                  cnt_q <= 5'h0;
               end
               else
               begin
                  cnt_q <= cnt_q + 5'h1;
               end
            end
            default:
            begin
               state_q <= psr_pkg::MS_IDLE;
            end
         endcase
      end
   end

   // Snapshot taken at the end of the first turnaround bit
   assign status_rd_ev = mdc_rise && state_q == psr_pkg::MS_TURN && cnt_q == 5'h0
      && op_q == psr_pkg::OP_READ && addr_hit && addr_q[4:0] == psr_pkg::REG_STATUS;
   assign adv_wr_ev = mdc_rise && state_q == psr_pkg::MS_DATA
      && cnt_q == psr_pkg::DATA_BITS - 5'h1 && op_q == psr_pkg::OP_WRITE && addr_hit
      && addr_q[4:0] == psr_pkg::REG_ADVERT;

   // Unmapped addresses stay released so other banks may answer
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mdio_o <= 1'b1;
         mdio_oe_n <= 1'b1;
         rd_active_q <= 1'b0;
         shift_q <= 16'h0;
      end
      else if (mdc_rise)
      begin
         if (state_q == psr_pkg::MS_TURN && cnt_q == 5'h0 && op_q == psr_pkg::OP_READ
            && addr_hit && reg_mapped)
         begin
            mdio_o <= 1'b0;
            mdio_oe_n <= 1'b0;
            rd_active_q <= 1'b1;
            shift_q <= rd_data;
         end
         else if (rd_active_q && state_q == psr_pkg::MS_TURN)
         begin
            mdio_o <= shift_q[15];
            shift_q <= {shift_q[14:0], 1'b0};
         end
         else if (rd_active_q && state_q == psr_pkg::MS_DATA)
         begin
            if (cnt_q == psr_pkg::DATA_BITS - 5'h1)
            begin
               mdio_o <= 1'b1;
               mdio_oe_n <= 1'b1;
               rd_active_q <= 1'b0;
            end
            else
            begin
               mdio_o <= shift_q[15];
               shift_q <= {shift_q[14:0], 1'b0};
            end
         end
         else if (state_q == psr_pkg::MS_DATA && !rd_active_q)
         begin
            shift_q <= {shift_q[14:0], bit_in};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latched status bits

   logic jab_latched_q;
   logic link_latched_q;
   logic fault_latched_q;

   // Set beats the read clear so no event slips between reads
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         jab_latched_q <= 1'b0;
         link_latched_q <= 1'b0;
         fault_latched_q <= 1'b0;
      end
      else if (sw_reset)
      begin
         jab_latched_q <= 1'b0;
         link_latched_q <= 1'b0;
         fault_latched_q <= 1'b0;
      end
      else if (status_rd_ev)
      begin
         jab_latched_q <= jabber_det;
         link_latched_q <= link_up;
         fault_latched_q <= remote_fault_det;
      end
      else
      begin
         jab_latched_q <= jab_latched_q | jabber_det;
         link_latched_q <= link_latched_q & link_up;
         fault_latched_q <= fault_latched_q | remote_fault_det;
      end
   end

   // Fixed capability bits plus live and latched bits
   always_comb
   begin
      status_rd = psr_pkg::STATUS_FIXED;
      status_rd[psr_pkg::ST_JABBER] = jab_latched_q;
      status_rd[psr_pkg::ST_LINK] = link_latched_q;
      status_rd[psr_pkg::ST_REM_FAULT] = fault_latched_q;
      status_rd[psr_pkg::ST_AN_DONE] = an_complete;
   end

   always_comb
   begin
      unique case (addr_q[4:0])
         psr_pkg::REG_STATUS: rd_data = status_rd;
         psr_pkg::REG_ID_HIGH: rd_data = ID_HIGH;
         psr_pkg::REG_ID_LOW: rd_data = {ORG_ID_LOW, MODEL_NUM, REV_NUM};
         psr_pkg::REG_ADVERT: rd_data = adv_q;
         default: rd_data = 16'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Advertisement register

   // Read-only fields forced on every write keep the selector legal
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         adv_q <= psr_pkg::ADV_RESET;
      end
      else if (sw_reset)
      begin
         adv_q <= psr_pkg::ADV_RESET;
      end
      else if (adv_wr_ev)
      begin
         adv_q <= ({shift_q[14:0], bit_in} & psr_pkg::ADV_WR_MASK)
            | (psr_pkg::ADV_RESET & ~psr_pkg::ADV_WR_MASK);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   sequence s_drive_start;
      $fell(mdio_oe_n) ##0 !mdio_o;
   endsequence

   status_fixed_a: assert property (status_rd[15:6] == 10'h1e5 && status_rd[3] && status_rd[0])
      else $error("fixed status bits wrong");
   jabber_set_a: assert property (jabber_det && !sw_reset |=> jab_latched_q)
      else $error("jabber not latched");
   jabber_hold_a: assert property (jab_latched_q && !status_rd_ev && !sw_reset
      |=> jab_latched_q)
      else $error("jabber latch dropped");
   link_low_a: assert property (!link_up |=> !link_latched_q)
      else $error("link loss not latched");
   fault_set_a: assert property (remote_fault_det && !sw_reset |=> fault_latched_q)
      else $error("remote fault not latched");
   read_refresh_a: assert property (status_rd_ev && !sw_reset
      |=> link_latched_q == $past(link_up))
      else $error("status read did not refresh");
   soft_reset_a: assert property (sw_reset |=> adv_q == psr_pkg::ADV_RESET && !jab_latched_q)
      else $error("software reset values not applied");
   adv_fixed_a: assert property (adv_q[4:0] == psr_pkg::ADV_SELECTOR && !adv_q[9]
      && !adv_q[12] && !adv_q[14])
      else $error("advertisement read-only field changed");
   drive_hold_a: assert property (s_drive_start |=> !mdio_oe_n [*8])
      else $error("read drive released early");
   idle_quiet_a: assert property (state_q == psr_pkg::MS_IDLE |-> mdio_oe_n)
      else $error("driving outside a read frame");
endmodule

// ### tb/psr_mdio_host.sv
// Purpose: Management host model that clocks read and write frames into the bank
// Assumes: Pull-up on the data wire; the device answers a few mclk after each mdc rise
// Notes: Each mdc phase lasts 8 mclk, four times the minimum, to leave sampling margin
`timescale 1ns/100ps
module psr_mdio_host (
   input wire logic mclk, // System clock
   input wire logic mdio_o, // Device data out
   input wire logic mdio_oe_n, // Device drive enable, active low
   output logic mdc, // Management clock
   output logic mdio_i // Resolved data wire level
);
   logic h_d, h_oe;

   // Nobody driving: the pull-up wins
   assign mdio_i = !mdio_oe_n ? mdio_o : (h_oe ? h_d : 1'b1);

   initial
   begin
      mdc = 1'b0;
      h_d = 1'b1;
      h_oe = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic bit_cyc(input logic d, input logic drv, output logic s);
      @(posedge mclk);
      mdc <= 1'b0;
      h_d <= d;
      h_oe <= drv;
      repeat (8) @(posedge mclk);
      s = mdio_i;
      mdc <= 1'b1;
      repeat (7) @(posedge mclk);
   endtask

   // One idle bit, then start, opcode, addresses, turnaround and data
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ta2);
      logic [31:0] bits;
      logic s, rdop;
      bits = {2'b01, op, phy, rg, 2'b10, wd};
      rdop = (op == psr_pkg::OP_READ);
      rd = 16'h0000;
      ta2 = 1'b1;
      bit_cyc(1'b1, 1'b1, s);
      for (int i = 31; i >= 0; i--)
      begin
         // Host lets go of the wire from the turnaround on during reads
         bit_cyc(bits[i], !(rdop && i < 18), s);
         if (i == 16)
            ta2 = s;
         if (i < 16)
            rd[i] = s;
      end
      // Wire back to idle high between frames
      h_d <= 1'b1;
      h_oe <= 1'b1;
   endtask
endmodule

// ### tb/psr_regs_tb.sv
// Purpose: Self-checking bench for the status, identifier and advertisement bank
// Assumes: Host model owns mdc and mdio; live status inputs driven here
// Notes: Random advertisement words mixed with all-ones and all-zeros corners
`timescale 1ns/100ps
module psr_regs_tb;
   localparam logic [4:0] PHY = 5'h01;
   localparam logic [15:0] ID_H = 16'h3c96; // Arbitrary value
   localparam logic [5:0] MODEL = 6'h11; // Arbitrary value
   localparam logic [3:0] REV = 4'h7; // Arbitrary value
   localparam logic [5:0] ORGL = 6'h2d; // Arbitrary value
   logic mclk, arst_n, sw_reset, jabber_det, link_up, remote_fault_det, an_complete;
   logic mdc, mdio_i, mdio_o, mdio_oe_n, ta;
   logic [15:0] adv_q, rd, w;
   int n_errors, total_checks;

   psr_regs #(.PHY_ADDR(PHY), .ID_HIGH(ID_H), .MODEL_NUM(MODEL), .REV_NUM(REV),
      .ORG_ID_LOW(ORGL)) u_psr_regs (.mclk(mclk), .arst_n(arst_n), .sw_reset(sw_reset),
      .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
      .jabber_det(jabber_det), .link_up(link_up), .remote_fault_det(remote_fault_det),
      .an_complete(an_complete), .adv_q(adv_q));
   psr_mdio_host u_psr_mdio_host (.mclk(mclk), .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n),
      .mdc(mdc), .mdio_i(mdio_i));

   initial
      mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_reg(input logic [4:0] rg);
      u_psr_mdio_host.frame(psr_pkg::OP_READ, PHY, rg, 16'h0000, rd, ta);
   endtask

   // Write lands a few mclk after the last data bit
   task automatic wr_reg(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
      u_psr_mdio_host.frame(psr_pkg::OP_WRITE, phy, rg, d, rd, ta);
      repeat (4) @(posedge mclk);
   endtask

   function automatic logic [15:0] exp_st(input logic j, input logic l, input logic r,
                                          input logic a);
      return 16'h7949 | {10'h000, a, r, 1'b0, l, j, 1'b0};
   endfunction

   function automatic logic [15:0] exp_adv(input logic [15:0] d);
      return (d & 16'hade0) | 16'h0001;
   endfunction

   task automatic summarize;
      if (n_errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #2_000_000;
      n_errors++;
      summarize;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      arst_n = 1'b0;
      sw_reset = 1'b0;
      jabber_det = 1'b0;
      link_up = 1'b1;
      remote_fault_det = 1'b0;
      an_complete = 1'b0;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(93));
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk16(adv_q, 16'h81e1);
      rd_reg(psr_pkg::REG_ADVERT);
      chk16(rd, 16'h81e1);
      chk16({15'h0000, ta}, 16'h0000);
      // Link latch still holds its reset value on the first read
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(0, 0, 0, 0));
      an_complete <= 1'b1;
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(0, 1, 0, 1));
      // Short events must survive until the host reads them
      jabber_det <= 1'b1;
      link_up <= 1'b0;
      remote_fault_det <= 1'b1;
      repeat (4) @(posedge mclk);
      jabber_det <= 1'b0;
      link_up <= 1'b1;
      remote_fault_det <= 1'b0;
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(1, 0, 1, 1));
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(0, 1, 0, 1));
      for (int r = 1; r <= 3; r++)
         wr_reg(PHY, r[4:0], 16'h0000);
      rd_reg(psr_pkg::REG_ID_HIGH);
      chk16(rd, ID_H);
      rd_reg(psr_pkg::REG_ID_LOW);
      chk16(rd, {ORGL, MODEL, REV});
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(0, 1, 0, 1));
      for (int k = 0; k < 8; k++)
      begin
         w = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($urandom);
         wr_reg(PHY, psr_pkg::REG_ADVERT, w);
         chk16(adv_q, exp_adv(w));
         rd_reg(psr_pkg::REG_ADVERT);
         chk16(rd, exp_adv(w));
      end
      // Other station address and an unmapped register are never answered
      wr_reg(5'h02, psr_pkg::REG_ADVERT, ~w);
      chk16(adv_q, exp_adv(w));
      u_psr_mdio_host.frame(psr_pkg::OP_READ, 5'h02, psr_pkg::REG_STATUS, 16'h0000, rd, ta);
      chk16(rd, 16'hffff);
      rd_reg(5'h05);
      chk16(rd, 16'hffff);
      wr_reg(PHY, psr_pkg::REG_ADVERT, 16'h0000);
      jabber_det <= 1'b1;
      @(posedge mclk);
      jabber_det <= 1'b0;
      sw_reset <= 1'b1;
      @(posedge mclk);
      sw_reset <= 1'b0;
      @(posedge mclk);
      chk16(adv_q, 16'h81e1);
      rd_reg(psr_pkg::REG_STATUS);
      chk16(rd, exp_st(0, 0, 0, 1));
      wr_reg(PHY, psr_pkg::REG_ADVERT, 16'h0000);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      chk16(adv_q, 16'h81e1);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd_reg(psr_pkg::REG_ADVERT);
      chk16(rd, 16'h81e1);
      summarize;
   end
endmodule
